/* core/pacc_pkg.sv */
// Package of constants and types for the pulse accumulator and periodic timer block.
package pacc_pkg;

  // ----------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_IDX_ENABLE  = 16'h1024;
  localparam logic [15:0] REG_IDX_FLAGS   = 16'h1025;
  localparam logic [15:0] REG_IDX_CONTROL = 16'h1026;
  localparam logic [15:0] REG_IDX_COUNT   = 16'h1027;
  localparam int          ADR_W           = 16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_MAIN_OVF    = 7;
  localparam int BIT_PERIODIC    = 6;
  localparam int BIT_ACCUM_OVF   = 5;
  localparam int BIT_INPUT_EDGE  = 4;
  localparam int BIT_PORT7_DIR   = 7;
  localparam int BIT_ACCUM_EN    = 6;
  localparam int BIT_ACCUM_MODE  = 5;
  localparam int BIT_EDGE_CTRL   = 4;
  localparam int BIT_PORT3_DIR   = 3;
  localparam int BIT_CAP_CMP_SEL = 2;
  localparam int BIT_RATE_LO     = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_ENABLE   = 4'h0;
  localparam logic [1:0] RST_PRESCALE = 2'h0;
  localparam logic [3:0] RST_FLAGS    = 4'h0;
  localparam logic [7:0] RST_CONTROL  = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int          RTI_BASE_EXP   = 13;
  localparam int          RTI_BASE_DIV   = 2 ** RTI_BASE_EXP;
  localparam logic [5:0]  GATE_DIV_LAST  = 6'h3F;
  localparam logic [6:0]  PRESCALE_LIMIT = 7'h40;

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]              en;
    logic [1:0]              presc;
    logic                    presc_done;
    logic [6:0]              boot_cnt;
    logic [3:0]              flg;
    logic [7:0]              ctl;
    logic [RTI_BASE_EXP-1:0] rti_base;
    logic [2:0]              rti_rate;
    logic [5:0]              gate_div;
    logic [2:0]              sync;
    logic                    lvl;
    logic                    ack;
    logic [7:0]              rdat;
    logic                    irq;
  } pacc_state_type;

endpackage

/* core/pacc_top.sv */
// Pulse accumulator, periodic timer and shared timer enable and flag registers.
// Contract
// - Main overflow flag with its enable set raises the interrupt request.
// - Periodic flag with its enable set requests an interrupt; enable gates only request.
// - Upper four enable bits gate the flags at the same bit positions.
// - Enable register bits 3 and 2 always read zero.
// - Flag register low four bits always read zero.
// - Flags clear only by writing one; written zeros change nothing.
// - Main overflow flag sets when the main free counter wraps to zero.
// - Periodic flag sets at each interval end; written bit 6 clears it.
// - Periodic timer runs from E over two to the thirteenth, then rate divider.
// - Eight-bit counter; mode zero counts events, mode one accumulates gated time.
// - Accumulator enable bit zero disables, one enables the accumulator.
// - Gated mode increments on free E over 64 tick while input active.
// - Edge control selects counted edge, or which input level inhibits counting.
// - Select bit zero enables fifth compare, one fourth capture, never both.
// - Pulse count readable and writable anytime; reset leaves it unchanged.
// - Increments and bus reads of the count fall in separate phases.
// - Count rolling from all ones to zero sets overflow flag; bit 5 clears.
// - Overflow enable never affects the flag; when set, the flag requests.
// - Rate codes 00 to 11 give intervals of E over 2^13 to 2^16.
// - Intervals run from previous timeout; first flag after one full interval.
// - Input edge flag sets on selected edge while accumulator enabled, bit 4 clears, enable gates request.
// - Prescale select takes one write only, within 64 cycles after reset; in special mode any write sets it.
`timescale 1ns/1ps
`default_nettype none

module pacc_top #(
  parameter int unsigned RTI_BASE_CYCLES = pacc_pkg::RTI_BASE_DIV
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      clk_en_i,
  input  wire logic                      special_mode_i,
  input  wire logic                      main_overflow_i,
  input  wire logic                      pulse_input_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [pacc_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           timer_irq_o,
  output logic      [1:0]                prescale_select_o,
  output logic                           capture_compare_select_o,
  output logic                           port_bit7_direction_o,
  output logic                           port_bit3_direction_o
);
  import pacc_pkg::*;

  // ----------------------------------------------------------------
  // State and working signals
  // ----------------------------------------------------------------
  pacc_state_type          q;
  pacc_state_type          d;
  logic [7:0]              count_q;
  logic [7:0]              count_d;
  logic                    req;
  logic                    wr;
  logic                    wr_enable;
  logic                    wr_flags;
  logic                    wr_control;
  logic                    wr_count;
  logic                    stable_chg;
  logic                    sel_edge;
  logic                    gate_tick;
  logic                    active;
  logic                    inc;
  logic                    base_tick;
  logic [2:0]              rate_mask;
  logic                    rti_timeout;
  logic                    presc_open;
  logic [3:0]              flag_clr;
  logic [3:0]              flag_set;
  logic [7:0]              wdat;

  localparam logic [RTI_BASE_EXP-1:0] RTI_BASE_LAST = RTI_BASE_EXP'(RTI_BASE_CYCLES - 1);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [15:0] idx);
    hit = (adr == {idx[ADR_W-3:0], 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d           = q;
    count_d     = count_q;
    wdat        = wb_dat_i[7:0];
    req         = wb_cyc_i & wb_stb_i & ~q.ack;
    wr          = req & wb_we_i & wb_sel_i[0];
    wr_enable   = wr & hit(wb_adr_i, REG_IDX_ENABLE);
    wr_flags    = wr & hit(wb_adr_i, REG_IDX_FLAGS);
    wr_control  = wr & hit(wb_adr_i, REG_IDX_CONTROL);
    wr_count    = wr & hit(wb_adr_i, REG_IDX_COUNT);
    // The input counts as changed only once the second and third stages agree.
    stable_chg  = (q.sync[1] == q.sync[2]) && (q.sync[2] != q.lvl);
    sel_edge    = stable_chg && (q.sync[2] == q.ctl[BIT_EDGE_CTRL]);
    gate_tick   = (q.gate_div == GATE_DIV_LAST);
    active      = (q.lvl != q.ctl[BIT_EDGE_CTRL]);
    inc         = q.ctl[BIT_ACCUM_EN] &&
                  (q.ctl[BIT_ACCUM_MODE] ? (gate_tick && active) : sel_edge);
    base_tick   = (q.rti_base == RTI_BASE_LAST);
    rate_mask   = (3'h1 << q.ctl[BIT_RATE_LO +: 2]) - 3'h1;
    rti_timeout = base_tick && ((q.rti_rate & rate_mask) == rate_mask);
    presc_open  = special_mode_i || (!q.presc_done && (q.boot_cnt < PRESCALE_LIMIT));
    flag_clr    = wr_flags ? wdat[7:4] : 4'h0;
    flag_set    = {main_overflow_i, rti_timeout, inc && (count_q == 8'hFF),
                   sel_edge && q.ctl[BIT_ACCUM_EN]};
    if (clk_en_i) begin
      d.sync     = {q.sync[1:0], pulse_input_i};
      if (q.sync[1] == q.sync[2]) begin
        d.lvl = q.sync[2];
      end
      d.gate_div = q.gate_div + 6'h01;
      // The periodic chain never stops, so each interval runs from the last timeout.
      d.rti_base = base_tick ? '0 : q.rti_base + RTI_BASE_EXP'(1);
      if (base_tick) begin
        d.rti_rate = q.rti_rate + 3'h1;
      end
      if (q.boot_cnt < PRESCALE_LIMIT) begin
        d.boot_cnt = q.boot_cnt + 7'h01;
      end
      // A set arriving with its clear wins, so no event is lost.
      d.flg = (q.flg & ~flag_clr) | flag_set;
      if (wr_enable) begin
        d.en = wdat[7:4];
        if (presc_open) begin
          d.presc      = wdat[1:0];
          d.presc_done = 1'b1;
        end
      end
      if (wr_control) begin
        d.ctl = wdat;
      end
      // Increments land on the clock edge and reads capture the settled value from before it.
      if (wr_count) begin
        count_d = wdat;
      end else if (inc) begin
        count_d = count_q + 8'h01;
      end
      d.ack  = req;
      d.rdat = 8'h00;
      if (hit(wb_adr_i, REG_IDX_ENABLE)) begin
        d.rdat = {q.en, 2'b00, q.presc};
      end else if (hit(wb_adr_i, REG_IDX_FLAGS)) begin
        d.rdat = {q.flg, 4'h0};
      end else if (hit(wb_adr_i, REG_IDX_CONTROL)) begin
        d.rdat = q.ctl;
      end else if (hit(wb_adr_i, REG_IDX_COUNT)) begin
        d.rdat = count_q;
      end
      d.irq = |(d.flg & d.en);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q            <= '0;
      q.en         <= RST_ENABLE;
      q.presc      <= RST_PRESCALE;
      q.flg        <= RST_FLAGS;
      q.ctl        <= RST_CONTROL;
    end else begin
      q <= d;
    end
  end

  // The count keeps its value through reset, so it lives outside the reset domain.
  always_ff @(posedge ref_clk_i) begin
    count_q <= count_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o                 = {24'h000000, q.rdat};
  assign wb_ack_o                 = q.ack;
  assign timer_irq_o              = q.irq;
  assign prescale_select_o        = q.presc;
  assign capture_compare_select_o = q.ctl[BIT_CAP_CMP_SEL];
  assign port_bit7_direction_o    = q.ctl[BIT_PORT7_DIR];
  assign port_bit3_direction_o    = q.ctl[BIT_PORT3_DIR];

endmodule

`default_nettype wire

/* verif/pacc_props.sv */
// Port assertions for the pulse accumulator and periodic timer block.
`timescale 1ns/1ps
`default_nettype none
module pacc_props #(
  parameter int unsigned RTI_BASE_CYCLES = 16
) (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        clk_en_i,
  input wire logic        special_mode_i,
  input wire logic        main_overflow_i,
  input wire logic        pulse_input_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        timer_irq_o,
  input wire logic [1:0]  prescale_select_o,
  input wire logic        capture_compare_select_o,
  input wire logic        port_bit7_direction_o,
  input wire logic        port_bit3_direction_o
);
  import pacc_pkg::*;
  localparam logic [15:0] A_EN = 16'h4090;
  localparam logic [15:0] A_FL = 16'h4094;
  localparam logic [15:0] A_CT = 16'h4098;
  logic [3:0] en_q;
  logic [7:0] ct_q;
  logic [6:0] bc_q;
  logic       take;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i; endsequence
  sequence s_wr; s_take ##0 (wb_we_i && wb_sel_i[0]); endsequence
  // Shadows of software writes and a boot cycle count, so outputs can be tied back to their cause.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q <= 4'h0;
      ct_q <= 8'h00;
      bc_q <= 7'h00;
    end else begin
      if (clk_en_i && bc_q != 7'h7F) bc_q <= bc_q + 7'h01;
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == A_EN) en_q <= wb_dat_i[7:4];
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == A_CT) ct_q <= wb_dat_i[7:0];
    end
  end
  property p_ack; s_take |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_rd_en; wb_ack_o && !wb_we_i && wb_adr_i == A_EN |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[3:2] == 2'h0; endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable bits 3:2 not zero");
  property p_rd_fl; wb_ack_o && !wb_we_i && wb_adr_i == A_FL |-> wb_dat_o[3:0] == 4'h0; endproperty
  a_rd_fl: assert property (p_rd_fl) else $error("flag low bits not zero");
  property p_ovf_irq; main_overflow_i && clk_en_i && en_q[3] |-> ##[1:3] timer_irq_o; endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("no overflow request");
  property p_irq_mask; (en_q == 4'h0) ##1 (en_q == 4'h0) |-> !timer_irq_o; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request while masked");
  property p_ctl; s_wr ##0 (wb_adr_i == A_CT) |=> ##[0:1] (capture_compare_select_o == ct_q[2]
    && port_bit7_direction_o == ct_q[7] && port_bit3_direction_o == ct_q[3]); endproperty
  a_ctl: assert property (p_ctl) else $error("control outputs wrong");
  property p_presc; bc_q == 7'h7F && !special_mode_i |-> $stable(prescale_select_o); endproperty
  a_presc: assert property (p_presc) else $error("prescale changed late");
endmodule
bind pacc_top pacc_props #(.RTI_BASE_CYCLES(RTI_BASE_CYCLES)) pacc_props_i (.*);
`default_nettype wire

/* verif/pacc_pulse_src.sv */
// Model of the external event source on the pulse input pin.
`timescale 1ns/1ps
`default_nettype none
module pacc_pulse_src (
  input  wire logic ref_clk_i,
  input  wire logic run_i,
  input  wire logic lvl_i,
  output var logic  pin_o = 1'h0
);
  logic [1:0] cnt_q = 2'h0;
  // Toggling every fourth cycle keeps well below the E over two limit.
  always_ff @(posedge ref_clk_i) begin
    if (!run_i) begin
      cnt_q <= 2'h0;
      pin_o <= lvl_i;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3) pin_o <= ~pin_o;
    end
  end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the pulse accumulator and periodic timer block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pacc_pkg::*;
  localparam int BASE = 64;
  localparam logic [15:0] A_EN = 16'h4090, A_FL = 16'h4094, A_CT = 16'h4098, A_CN = 16'h409C;
  logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic        ovf = 1'h0, run = 1'h0, lvl = 1'h0, ce = 1'h1, ack, irq, ccs, p7, p3, pin;
  logic [1:0]  psel;
  logic [15:0] adr = 16'h0;
  logic [31:0] wdat = 32'h0, rdat, dout;
  int          error_cnt = 0, cmp_count = 0, now = 0, t0, t1;
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) now <= now + 1;
  pacc_top #(.RTI_BASE_CYCLES(BASE)) pacc_top_i (.ref_clk_i(clk), .arst_n_i(rst_n),
    .clk_en_i(ce), .special_mode_i(1'h0), .main_overflow_i(ovf), .pulse_input_i(pin),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .timer_irq_o(irq),
    .prescale_select_o(psel), .capture_compare_select_o(ccs),
    .port_bit7_direction_o(p7), .port_bit3_direction_o(p3));
  pacc_pulse_src pacc_pulse_src_i (.ref_clk_i(clk), .run_i(run), .lvl_i(lvl), .pin_o(pin));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (ack !== 1'h1) begin
      error_cnt++;
      $display("mismatch ack expected 1 seen %b", ack);
    end
    rdat = dout;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(string nm, logic [15:0] a, logic [7:0] e, logic [7:0] m);
    bus(1'h0, a, 8'h00);
    chk(nm, {24'h0, e}, rdat & {24'hFFFFFF, m});
  endtask
  task automatic rise(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'h1 && n < 2000);
    if (irq !== 1'h1) begin
      error_cnt++;
      $display("mismatch periodic_irq expected 1 seen %b", irq);
    end
    t = now;
    bus(1'h1, A_FL, 8'h40);
  endtask
  task automatic pulse_ovf(logic e);
    ovf <= 1'h1;
    @(posedge clk);
    ovf <= 1'h0;
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  // An odd toggle count tells rising from falling edges apart.
  task automatic pulses(int n, logic l);
    run <= 1'h1;
    repeat (n) @(posedge clk);
    run <= 1'h0;
    lvl <= l;
    repeat (8) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd("flags", A_FL, 8'h00, 8'hFF);
    rd("control", A_CT, 8'h00, 8'hFF);
    bus(1'h1, A_EN, 8'hFF);
    rd("enable", A_EN, 8'hF3, 8'hFF);
    bus(1'h1, A_EN, 8'h80);
    rd("enable", A_EN, 8'h83, 8'hFF);
    pulse_ovf(1'h1);
    bus(1'h1, A_FL, 8'h7F);
    rd("flags", A_FL, 8'h80, 8'hBF);
    bus(1'h1, A_EN, 8'h03);
    pulse_ovf(1'h0);
    bus(1'h1, A_EN, 8'h40);
    for (int r = 0; r < 4; r++) begin
      bus(1'h1, A_CT, 8'(r));
      rise(t0);
      rise(t0);
      rise(t1);
      chk("interval", 32'(BASE << r), 32'(t1 - t0));
    end
    bus(1'h1, A_EN, 8'h00);
    bus(1'h1, A_FL, 8'hF0);
    bus(1'h1, A_CT, 8'h50);
    bus(1'h1, A_CN, 8'hFD);
    pulses(28, 1'h1);
    rd("count", A_CN, 8'h01, 8'hFF);
    rd("flags", A_FL, 8'h30, 8'h3F);
    bus(1'h1, A_FL, 8'h30);
    bus(1'h1, A_CT, 8'h40);
    bus(1'h1, A_CN, 8'h10);
    pulses(28, 1'h0);
    rd("count", A_CN, 8'h14, 8'hFF);
    rd("flags", A_FL, 8'h10, 8'h3F);
    bus(1'h1, A_FL, 8'h10);
    bus(1'h1, A_CT, 8'h10);
    pulses(32, 1'h0);
    rd("count", A_CN, 8'h14, 8'hFF);
    bus(1'h1, A_CT, 8'h60);
    bus(1'h1, A_CN, 8'h00);
    lvl <= 1'h1;
    repeat (320) @(posedge clk);
    lvl <= 1'h0;
    repeat (8) @(posedge clk);
    rd("count", A_CN, 8'h05, 8'hFF);
    bus(1'h1, A_CT, 8'h8C);
    chk("ccsel", 32'h1, {31'h0, ccs});
    chk("port7_dir", 32'h1, {31'h0, p7});
    chk("port3_dir", 32'h1, {31'h0, p3});
    chk("prescale", 32'h3, {30'h0, psel});
    ce <= 1'h0;
    ovf <= 1'h1;
    @(posedge clk);
    ovf <= 1'h0;
    repeat (3) @(posedge clk);
    ce <= 1'h1;
    @(posedge clk);
    rd("frozen_flags", A_FL, 8'h00, 8'h80);
    rd("unmapped", 16'h40A0, 8'h00, 8'hFF);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
